// >>> rtl/clu_pkg.sv
// Contract
// - Each table has an enable at bit 0; it works only while that bit is one.
// - Input 1 selector lives in bits 7:4 of the first input-select register.
// - Input 0 selector lives in bits 3:0 of the first input-select register.
// - Input 2 selector lives in bits 3:0 of the second select register.
// - Code 0 masks, code 1 routes feedback, code 2 routes the other table.
// - Code 3 routes event channel a, code 4 routes event channel b.
// - Code 5 routes the table's own pin with the input's index.
// - Code 6 routes the comparator, code 7 the capture timer waveform.
// - Code 8 routes the period timer channel equal to the input index.
// - Input 0: code A routes serial transfer clock, code B routes SPI SCK.
// - Input 1: code A routes serial TXD, code B routes SPI MOSI.
// - Input 2: code A is unconnected, code B routes SPI MISO.
// - Each table holds an 8-bit pattern; output is the bit the inputs pick.
// - Registers repeat every 4 bytes; table zero at 0x05, 0x06, 0x07, 0x08.
// - With the clock choice bit set, input 2 counts as masked low.
package clu_pkg;
    localparam int CLU_TABLES = 2;
    localparam int CLU_INPUTS = 3;

    localparam logic [7:0] CLU_OFS_CTRL = 8'h05;
    localparam logic [7:0] CLU_OFS_SEL01 = 8'h06;
    localparam logic [7:0] CLU_OFS_SEL2 = 8'h07;
    localparam logic [7:0] CLU_OFS_TRUTH = 8'h08;
    localparam logic [7:0] CLU_OFS_STRIDE = 8'h04;

    localparam int CLU_BIT_ENABLE = 0;
    localparam int CLU_BIT_CLKCHOICE = 6;
    localparam int CLU_SEL1_LSB = 4;
    localparam int CLU_SEL0_LSB = 0;
    localparam int CLU_SEL2_LSB = 0;

    localparam logic [7:0] CLU_REG_RESET = 8'h00;

    localparam logic [3:0] CLU_SRC_MASK = 4'h0;
    localparam logic [3:0] CLU_SRC_FEEDBACK = 4'h1;
    localparam logic [3:0] CLU_SRC_LINK = 4'h2;
    localparam logic [3:0] CLU_SRC_EVENT_A = 4'h3;
    localparam logic [3:0] CLU_SRC_EVENT_B = 4'h4;
    localparam logic [3:0] CLU_SRC_PIN = 4'h5;
    localparam logic [3:0] CLU_SRC_COMPARATOR = 4'h6;
    localparam logic [3:0] CLU_SRC_CAPTURE = 4'h7;
    localparam logic [3:0] CLU_SRC_PERIOD = 4'h8;
    localparam logic [3:0] CLU_SRC_SERIAL = 4'hA;
    localparam logic [3:0] CLU_SRC_SPI = 4'hB;

    typedef struct packed {
        logic [CLU_TABLES-1:0] en;
        logic [CLU_TABLES-1:0] clk_choice;
        logic [CLU_TABLES-1:0][7:0] sel01;
        logic [CLU_TABLES-1:0][3:0] sel2;
        logic [CLU_TABLES-1:0][7:0] truth;
        logic [CLU_TABLES-1:0] out;
        logic [7:0] rdata;
        logic [6:0] sync1;
        logic [6:0] sync2;
    } clu_state_t;

    localparam clu_state_t CLU_STATE_RESET = '0;

    // True when addr is register base of table n
    function automatic logic clu_hit(input logic [7:0] addr, input logic [7:0] base,
                                     input int n);
        clu_hit = (addr == base + 8'(n) * CLU_OFS_STRIDE);
    endfunction
endpackage

// >>> rtl/clu_src_mux.sv
`timescale 1ns/1ps
`default_nettype none
module clu_src_mux
    import clu_pkg::*;
(
    input wire logic [3:0] sel, // Source code
    input wire logic feedback, // Own table output
    input wire logic link, // Other table output
    input wire logic event_channel_a, // Event channel zero
    input wire logic event_channel_b, // Event channel one
    input wire logic pin, // Synchronised pin of this index
    input wire logic cmp, // Synchronised comparator
    input wire logic capture, // Capture timer waveform
    input wire logic period, // Period timer channel of this index
    input wire logic serial, // Serial signal of this index, 0 if none
    input wire logic spi, // SPI signal of this index
    output logic value // Selected input
);
    always_comb begin
        case (sel)
            CLU_SRC_MASK: value = 1'b0;
            CLU_SRC_FEEDBACK: value = feedback;
            CLU_SRC_LINK: value = link;
            CLU_SRC_EVENT_A: value = event_channel_a;
            CLU_SRC_EVENT_B: value = event_channel_b;
            CLU_SRC_PIN: value = pin;
            CLU_SRC_COMPARATOR: value = cmp;
            CLU_SRC_CAPTURE: value = capture;
            CLU_SRC_PERIOD: value = period;
            CLU_SRC_SERIAL: value = serial;
            CLU_SRC_SPI: value = spi;
            default: value = 1'b0;
        endcase
    end
endmodule // clu_src_mux
`default_nettype wire

// >>> rtl/clu_truth.sv
`timescale 1ns/1ps
`default_nettype none
module clu_truth
    import clu_pkg::*;
(
    input wire logic [7:0] pattern, // Truth pattern
    input wire logic [CLU_INPUTS-1:0] in, // Selected inputs
    input wire logic clk_choice, // Input 2 used as clock
    input wire logic en, // Table enabled
    output logic value // Next table output
);
    logic [2:0] idx;

    always_comb begin
        idx = {in[2] & ~clk_choice, in[1], in[0]};
        value = en & pattern[idx];
    end
endmodule // clu_truth
`default_nettype wire

// >>> rtl/clu_top.sv
`timescale 1ns/1ps
`default_nettype none
module clu_top
    import clu_pkg::*;
(
    input wire logic clk, // 25 MHz clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic event_channel_a, // Event channel zero
    input wire logic event_channel_b, // Event channel one
    input wire logic [5:0] lut_pin_in, // Pins, table n input i at 3n+i
    input wire logic comparator_output_source, // Comparator, asynchronous
    input wire logic capture_timer_waveform, // Capture timer waveform
    input wire logic [2:0] period_timer_waveform, // Period timer channels
    input wire logic serial_transfer_clock, // Serial port clock output
    input wire logic serial_port_source_txd, // Serial port transmit data
    input wire logic spi_source_sck, // SPI clock
    input wire logic spi_source_mosi, // SPI master out
    input wire logic spi_source_miso, // SPI master in
    output logic [1:0] lut_out // Table outputs
);
    clu_state_t s_r;
    clu_state_t s_nxt;
    logic [CLU_TABLES-1:0][CLU_INPUTS-1:0] tin;
    logic [CLU_TABLES-1:0] tval;
    logic [CLU_INPUTS-1:0] serial_pick;
    logic [CLU_INPUTS-1:0] spi_pick;
    logic [5:0] pin_s;
    logic cmp_s;

    // Serial port has nothing for input 2
    assign serial_pick = {1'b0, serial_port_source_txd, serial_transfer_clock};
    assign spi_pick = {spi_source_miso, spi_source_mosi, spi_source_sck};
    assign pin_s = s_r.sync2[5:0];
    assign cmp_s = s_r.sync2[6];

    genvar n;
    genvar i;
    generate
        for (n = 0; n < CLU_TABLES; n++) begin : g_tbl
            for (i = 0; i < CLU_INPUTS; i++) begin : g_in
                logic [3:0] sel;
                if (i == 0) begin : g_s0
                    assign sel = s_r.sel01[n][CLU_SEL0_LSB +: 4];
                end else if (i == 1) begin : g_s1
                    assign sel = s_r.sel01[n][CLU_SEL1_LSB +: 4];
                end else begin : g_s2
                    assign sel = s_r.sel2[n];
                end
                clu_src_mux u_mux (
                    .sel(sel),
                    .feedback(s_r.out[n]),
                    .link(s_r.out[1-n]),
                    .event_channel_a(event_channel_a),
                    .event_channel_b(event_channel_b),
                    .pin(pin_s[n*CLU_INPUTS+i]),
                    .cmp(cmp_s),
                    .capture(capture_timer_waveform),
                    .period(period_timer_waveform[i]),
                    .serial(serial_pick[i]),
                    .spi(spi_pick[i]),
                    .value(tin[n][i])
                );
            end
            clu_truth u_truth (
                .pattern(s_r.truth[n]),
                .in(tin[n]),
                .clk_choice(s_r.clk_choice[n]),
                .en(s_r.en[n]),
                .value(tval[n])
            );
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        // Pins and comparator are asynchronous: two flops before use
        s_nxt.sync1 = {comparator_output_source, lut_pin_in};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.out = tval;
        s_nxt.rdata = 8'h00;
        for (int k = 0; k < CLU_TABLES; k++) begin
            if (reg_wr && clu_hit(reg_addr, CLU_OFS_CTRL, k)) begin
                s_nxt.en[k] = reg_wdata[CLU_BIT_ENABLE];
                // Clock choice only moves while off, avoids glitching input 2
                if (!s_r.en[k]) begin
                    s_nxt.clk_choice[k] = reg_wdata[CLU_BIT_CLKCHOICE];
                end
            end
            // Select and truth writes while enabled are dropped silently
            if (reg_wr && !s_r.en[k]) begin
                if (clu_hit(reg_addr, CLU_OFS_SEL01, k)) begin
                    s_nxt.sel01[k] = reg_wdata;
                end
                if (clu_hit(reg_addr, CLU_OFS_SEL2, k)) begin
                    s_nxt.sel2[k] = reg_wdata[CLU_SEL2_LSB +: 4];
                end
                if (clu_hit(reg_addr, CLU_OFS_TRUTH, k)) begin
                    s_nxt.truth[k] = reg_wdata;
                end
            end
            if (reg_rd) begin
                if (clu_hit(reg_addr, CLU_OFS_CTRL, k)) begin
                    s_nxt.rdata[CLU_BIT_ENABLE] = s_r.en[k];
                    s_nxt.rdata[CLU_BIT_CLKCHOICE] = s_r.clk_choice[k];
                end
                if (clu_hit(reg_addr, CLU_OFS_SEL01, k)) begin
                    s_nxt.rdata = s_r.sel01[k];
                end
                if (clu_hit(reg_addr, CLU_OFS_SEL2, k)) begin
                    s_nxt.rdata = {4'h0, s_r.sel2[k]};
                end
                if (clu_hit(reg_addr, CLU_OFS_TRUTH, k)) begin
                    s_nxt.rdata = s_r.truth[k];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= CLU_STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign lut_out = s_r.out;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_off_low: assert property (!s_r.en[0] |=> !lut_out[0])
        else $error("disabled table drove a high output");

    a_mask_index: assert property (
        s_r.en[1] && s_r.sel01[1] == 8'h00 && s_r.sel2[1] == 4'h0
        |=> lut_out[1] == $past(s_r.truth[1][0]))
        else $error("masked inputs did not pick pattern bit 0");

    a_sel_locked: assert property (
        reg_wr && reg_addr == CLU_OFS_SEL01 && s_r.en[0]
        |=> s_r.sel01[0] == $past(s_r.sel01[0]))
        else $error("select written while table enabled");

    a_sel_open: assert property (
        reg_wr && reg_addr == CLU_OFS_SEL01 + CLU_OFS_STRIDE && !s_r.en[1]
        |=> s_r.sel01[1] == $past(reg_wdata))
        else $error("select write lost while table disabled");

    a_read_truth: assert property (
        reg_rd && reg_addr == CLU_OFS_TRUTH
        |=> reg_rdata == $past(s_r.truth[0]) ##1 reg_rdata == 8'h00 || $past(reg_rd))
        else $error("truth readback wrong or stale");

    a_event_route: assert property (
        s_r.en[0] && s_r.sel01[0] == {CLU_SRC_MASK, CLU_SRC_EVENT_A} &&
        s_r.sel2[0] == CLU_SRC_MASK
        |=> lut_out[0] == $past(s_r.truth[0][{2'b00, event_channel_a}]))
        else $error("event channel a not routed to input 0");

    a_clk_masks: assert property (
        s_r.en[0] && s_r.clk_choice[0] && s_r.sel01[0] == 8'h00 &&
        s_r.sel2[0] == CLU_SRC_SPI
        |=> lut_out[0] == $past(s_r.truth[0][0]))
        else $error("input 2 not masked under clock choice");

    a_reserved_low: assert property (
        s_r.en[1] && s_r.sel01[1] == 8'h99 && s_r.sel2[1] == 4'hF
        |=> lut_out[1] == $past(s_r.truth[1][0]))
        else $error("reserved code did not act as masked");

    a_link_route: assert property (
        s_r.en[1] && s_r.sel01[1] == {CLU_SRC_LINK, CLU_SRC_MASK} &&
        s_r.sel2[1] == CLU_SRC_PERIOD
        |=> lut_out[1] == $past(s_r.truth[1][{period_timer_waveform[2], lut_out[0], 1'b0}]))
        else $error("link or period channel misrouted");

    a_pin_delay: assert property (
        s_r.en[0] && s_r.sel01[0] == {4'h0, CLU_SRC_PIN} && s_r.sel2[0] == 4'h0
        |=> lut_out[0] == $past(s_r.truth[0][{2'b00, $past(lut_pin_in[0], 2)}]))
        else $error("pin not routed after two sync stages");
endmodule // clu_top
`default_nettype wire

// >>> bench/clu_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module clu_far_side (
    input wire logic clk, // Same clock as the block
    input wire logic sys_rst, // Async reset, active high
    input wire logic [31:0] rnd, // Fresh random levels
    input wire logic masters, // SPI and serial units run as master
    output logic [17:0] lv // Source levels, see bench for the bit map
);
    // Slave units give no valid levels, so those lines stay low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lv <= '0;
        end else begin
            lv[12:0] <= rnd[12:0];
            lv[17:13] <= masters ? rnd[17:13] : 5'h00;
        end
    end
endmodule // clu_far_side
`default_nettype wire

// >>> bench/test_lut_input_select_truth.sv
`timescale 1ns/1ps
`default_nettype none
module test_lut_input_select_truth;
    import clu_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, masters = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] lut_out, m_out, nx;
    logic [31:0] rnd = 32'h0, seed = 32'd94958;
    logic [17:0] lv;
    logic [6:0] sy1, sy2;
    logic [1:0] m_en, m_ck;
    logic [7:0] m_s01 [2], m_tr [2], m_rd;
    logic [3:0] m_s2 [2];
    logic i0, i1, i2, en_old;
    int n_errors = 0, total_checks = 0;

    always #20 clk = ~clk;

    clu_far_side far (.clk(clk), .sys_rst(sys_rst), .rnd(rnd), .masters(masters), .lv(lv));

    clu_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_channel_a(lv[0]),
        .event_channel_b(lv[1]), .lut_pin_in(lv[7:2]), .comparator_output_source(lv[8]),
        .capture_timer_waveform(lv[9]), .period_timer_waveform(lv[12:10]),
        .serial_transfer_clock(lv[13]), .serial_port_source_txd(lv[14]),
        .spi_source_sck(lv[15]), .spi_source_mosi(lv[16]), .spi_source_miso(lv[17]),
        .lut_out(lut_out));

    always @(posedge clk) begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd <= seed;
    end

    function automatic logic src(int n, int i, logic [3:0] c);
        case (c)
            4'h0: src = 1'b0;
            4'h1: src = m_out[n];
            4'h2: src = m_out[1-n];
            4'h3: src = lv[0];
            4'h4: src = lv[1];
            4'h5: src = sy2[3*n+i];
            4'h6: src = sy2[6];
            4'h7: src = lv[9];
            4'h8: src = lv[10+i];
            4'hA: src = (i == 2) ? 1'b0 : lv[13+i];
            4'hB: src = lv[15+i];
            default: src = 1'b0;
        endcase
    endfunction

    // Reference model, one step per rising edge
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            m_out = 2'b00; m_en = 2'b00; m_ck = 2'b00; m_rd = 8'h00; sy1 = '0; sy2 = '0;
            for (int n = 0; n < 2; n++) begin
                m_s01[n] = 8'h00; m_s2[n] = 4'h0; m_tr[n] = 8'h00;
            end
        end else begin
            for (int n = 0; n < 2; n++) begin
                i0 = src(n, 0, m_s01[n][3:0]);
                i1 = src(n, 1, m_s01[n][7:4]);
                i2 = src(n, 2, m_s2[n]) & ~m_ck[n];
                nx[n] = m_en[n] & m_tr[n][{i2, i1, i0}];
            end
            m_rd = 8'h00;
            for (int n = 0; n < 2; n++) begin
                en_old = m_en[n];
                if (reg_rd && reg_addr == 8'h05 + 8'(4*n)) m_rd = {1'b0, m_ck[n], 5'h00, m_en[n]};
                if (reg_rd && reg_addr == 8'h06 + 8'(4*n)) m_rd = m_s01[n];
                if (reg_rd && reg_addr == 8'h07 + 8'(4*n)) m_rd = {4'h0, m_s2[n]};
                if (reg_rd && reg_addr == 8'h08 + 8'(4*n)) m_rd = m_tr[n];
                if (reg_wr && reg_addr == 8'h05 + 8'(4*n)) begin
                    m_en[n] = reg_wdata[0];
                    if (!en_old) m_ck[n] = reg_wdata[6];
                end
                if (reg_wr && !en_old && reg_addr == 8'h06 + 8'(4*n)) m_s01[n] = reg_wdata;
                if (reg_wr && !en_old && reg_addr == 8'h07 + 8'(4*n)) m_s2[n] = reg_wdata[3:0];
                if (reg_wr && !en_old && reg_addr == 8'h08 + 8'(4*n)) m_tr[n] = reg_wdata;
            end
            m_out = nx;
            sy2 = sy1;
            sy1 = {lv[8], lv[7:2]};
        end
    end

    always @(negedge clk) begin
        if (!sys_rst) begin
            total_checks += 2;
            if (lut_out !== m_out) begin
                n_errors++;
                $display("[ERR] %0t table outputs %b, model %b", $time, lut_out, m_out);
            end
            if (reg_rdata !== m_rd) begin
                n_errors++;
                $display("[ERR] %0t read data %h, model %h", $time, reg_rdata, m_rd);
            end
        end
    end

    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(40ns * 6000);
        n_errors++;
        $display("[ERR] %0t run did not finish", $time);
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a++) acc(1'b0, 1'b1, 8'(a), 8'h00);
        for (int k = 0; k < 48; k++) begin
            masters <= (k < 40);
            // Walk all sixteen codes through every selector
            for (int n = 0; n < 2; n++) begin
                acc(1'b1, 1'b0, 8'h06 + 8'(4*n), {4'(k+5+n), 4'(k+n)});
                acc(1'b1, 1'b0, 8'h07 + 8'(4*n), {rnd[7:4], 4'(k+9+n)});
                acc(1'b1, 1'b0, 8'h08 + 8'(4*n), rnd[15:8]);
            end
            acc(1'b1, 1'b0, 8'h05, {1'b0, rnd[3], 6'h01});
            acc(1'b1, 1'b0, 8'h09, {1'b0, rnd[4], 6'h01});
            repeat (12) acc(1'b0, 1'b0, 8'h00, 8'h00);
            // Writes while enabled must be ignored
            for (int a = 5; a < 13; a++) acc(1'b1, 1'b0, 8'(a), rnd[7:0] | 8'h01);
            for (int a = 3; a < 15; a++) acc(1'b0, 1'b1, 8'(a), 8'h00);
            repeat (4) acc(1'b0, 1'b0, 8'h00, 8'h00);
            if (k == 24) begin
                sys_rst <= 1'b1;
                repeat (3) @(posedge clk);
                sys_rst <= 1'b0;
                @(posedge clk);
            end
            acc(1'b1, 1'b0, 8'h05, 8'h00);
            acc(1'b1, 1'b0, 8'h09, 8'h00);
            acc(1'b0, 1'b0, 8'h00, 8'h00);
        end
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule // test_lut_input_select_truth
`default_nettype wire
